/* design/adv_pkg.sv */
package adv_pkg;

  // ==========================================================
  // sizes
  localparam int CH_NUM   = 8;
  localparam int DW       = 16;
  localparam int CH_W     = 3;
  localparam int TMR_W    = 16;

  // ==========================================================
  // timing: times in ns, counts derived from the clock
  localparam int CLK_PERIOD_NS  = 50;
  localparam int CYCLE_STD_NS   = 1000000;  // 1.0 ms per point
  localparam int CYCLE_FAST_NS  = 250000;   // 250 us per point
  localparam int CYCLE_STD_CNT  = CYCLE_STD_NS / CLK_PERIOD_NS;
  localparam int CYCLE_FAST_CNT = CYCLE_FAST_NS / CLK_PERIOD_NS;

  // ==========================================================
  // resolutions, margins and scaling limit
  localparam logic signed [DW-1:0] RES_STD     = 16'sh0fa0;  // 4000
  localparam logic signed [DW-1:0] RES_HIGH    = 16'sh1f40;  // 8000
  localparam logic signed [DW-1:0] MARGIN_STD  = 16'sh00c8;  // 200
  localparam logic signed [DW-1:0] MARGIN_HIGH = 16'sh0190;  // 400
  localparam logic signed [DW-1:0] SCALE_LIM   = 16'sh7d00;  // 32000

  // ==========================================================
  // signal ranges per channel
  localparam logic [1:0] RANGE_1_5V   = 2'h0;  // also 4 to 20 mA
  localparam logic [1:0] RANGE_0_10V  = 2'h1;
  localparam logic [1:0] RANGE_0_5V   = 2'h2;
  localparam logic [1:0] RANGE_BIPOL  = 2'h3;  // -10 to +10 V

  // hold states; unused code behaves as clear
  localparam logic [1:0] HOLD_CLEAR   = 2'h0;
  localparam logic [1:0] HOLD_KEEP    = 2'h1;
  localparam logic [1:0] HOLD_MAX     = 2'h2;

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN  = 2'b10
  } adv_seq_type;

  // ==========================================================
  // range endpoints
  function automatic logic signed [DW-1:0] range_min(input logic [1:0] rng,
                                                     input logic       res_hi);
    logic signed [DW-1:0] full;
    full = res_hi ? RES_HIGH : RES_STD;
    if (rng == RANGE_BIPOL) begin
      range_min = -(full >>> 1);
    end else begin
      range_min = '0;
    end
  endfunction : range_min

  function automatic logic signed [DW-1:0] range_max(input logic [1:0] rng,
                                                     input logic       res_hi);
    logic signed [DW-1:0] full;
    full = res_hi ? RES_HIGH : RES_STD;
    if (rng == RANGE_BIPOL) begin
      range_max = full >>> 1;
    end else begin
      range_max = full;
    end
  endfunction : range_max

endpackage : adv_pkg

/* design/adv_point_if.sv */
`timescale 1ns/1ps
interface adv_point_if;
  logic signed [adv_pkg::DW-1:0] set_value;
  logic [1:0]                    range_sel;
  logic [1:0]                    hold_mode;
  logic                          res_hi;
  logic                          scale_on;
  logic signed [adv_pkg::DW-1:0] scale_lower;
  logic signed [adv_pkg::DW-1:0] scale_upper;
  logic signed [adv_pkg::DW-1:0] last_code;
  logic                          hold_req;
  logic signed [adv_pkg::DW-1:0] code;
  logic                          range_err;

  modport seq (output set_value, range_sel, hold_mode, res_hi, scale_on,
               output scale_lower, scale_upper, last_code, hold_req,
               input  code, range_err);
  modport core (input  set_value, range_sel, hold_mode, res_hi, scale_on,
                input  scale_lower, scale_upper, last_code, hold_req,
                output code, range_err);
endinterface : adv_point_if

/* design/adv_point_core.sv */
`timescale 1ns/1ps
module adv_point_core (
  adv_point_if.core pt
);

  logic signed [adv_pkg::DW-1:0] rmin;
  logic signed [adv_pkg::DW-1:0] rmax;
  logic signed [adv_pkg::DW-1:0] margin;
  logic signed [31:0]            num;
  logic signed [31:0]            den;
  logic signed [31:0]            scaled;
  logic signed [adv_pkg::DW-1:0] conv;
  logic                          err;

  // ==========================================================
  // range check, scaling and hold selection
  always_comb begin
    rmin   = adv_pkg::range_min(pt.range_sel, pt.res_hi);
    rmax   = adv_pkg::range_max(pt.range_sel, pt.res_hi);
    margin = pt.res_hi ? adv_pkg::MARGIN_HIGH : adv_pkg::MARGIN_STD;
    num    = '0;
    den    = 32'sh00000001;
    scaled = '0;
    conv   = pt.set_value;
    err    = 1'b0;
    if (pt.scale_on) begin
      err = (pt.scale_upper > adv_pkg::SCALE_LIM) ||
            (pt.scale_lower < -adv_pkg::SCALE_LIM) ||
            (pt.scale_upper <= pt.scale_lower) ||
            (pt.set_value < pt.scale_lower) ||
            (pt.set_value > pt.scale_upper);
      if (!err) begin
        num    = (32'(pt.set_value) - 32'(pt.scale_lower)) * (32'(rmax) - 32'(rmin));
        den    = 32'(pt.scale_upper) - 32'(pt.scale_lower);
        scaled = 32'(rmin) + num / den;
        conv   = scaled[adv_pkg::DW-1:0];
      end
    end else begin
      err = (pt.set_value < rmin - margin) || (pt.set_value > rmax + margin);
    end
    pt.range_err = err;
    if (pt.hold_req || err) begin
      case (pt.hold_mode)
        adv_pkg::HOLD_KEEP: pt.code = pt.last_code;
        adv_pkg::HOLD_MAX:  pt.code = rmax;
        default:            pt.code = rmin;  // hold_state_clear
      endcase
    end else begin
      pt.code = conv;
    end
  end

endmodule : adv_point_core

/* design/adv_output_ctrl.sv */
`timescale 1ns/1ps
module adv_output_ctrl #(
  parameter int STD_CNT  = adv_pkg::CYCLE_STD_CNT,
  parameter int FAST_CNT = adv_pkg::CYCLE_FAST_CNT
) (
  input  wire logic                                           clk,
  input  wire logic                                           rst,
  input  wire logic                                           host_run,
  input  wire logic                                           cfg_res_high,
  input  wire logic                                           cfg_fast_cycle,
  input  wire logic                                           cfg_scale_en,
  input  wire logic [adv_pkg::CH_NUM-1:0]                     conv_enable_set,
  input  wire logic [adv_pkg::CH_NUM-1:0]                     conv_enable_clr,
  input  wire logic [adv_pkg::CH_NUM-1:0][1:0]                range_sel,
  input  wire logic [adv_pkg::CH_NUM-1:0][1:0]                hold_mode,
  input  wire logic [adv_pkg::CH_NUM-1:0][adv_pkg::DW-1:0]    set_value,
  input  wire logic [adv_pkg::CH_NUM-1:0][adv_pkg::DW-1:0]    scale_lower,
  input  wire logic [adv_pkg::CH_NUM-1:0][adv_pkg::DW-1:0]    scale_upper,
  output logic      [adv_pkg::CH_NUM-1:0][adv_pkg::DW-1:0]    dac_code,
  output logic                                                dac_load,
  output logic      [adv_pkg::CH_W-1:0]                       dac_channel,
  output logic      [adv_pkg::CH_NUM-1:0]                     conv_enable_flag,
  output logic      [adv_pkg::CH_NUM-1:0]                     setting_error,
  output logic                                                res_high_active,
  output logic                                                fast_active,
  output logic                                                scale_active
);

  localparam logic [adv_pkg::TMR_W-1:0] STD_LAST  = adv_pkg::TMR_W'(STD_CNT - 1);
  localparam logic [adv_pkg::TMR_W-1:0] FAST_LAST = adv_pkg::TMR_W'(FAST_CNT - 1);

  adv_point_if pt ();

  adv_point_core adv_point_core_inst (
    .pt (pt.core)
  );

  // ==========================================================
  // sequencer state
  adv_pkg::adv_seq_type              state;
  adv_pkg::adv_seq_type              next_state;
  logic [adv_pkg::TMR_W-1:0]         timer;
  logic [adv_pkg::TMR_W-1:0]         next_timer;
  logic [adv_pkg::CH_W-1:0]          ch;
  logic [adv_pkg::CH_W-1:0]          next_ch;
  logic                              next_res_high_active;
  logic                              next_fast_active;
  logic                              next_scale_active;
  logic                              point_done;

  // settings are latched once after reset, then frozen
  always_comb begin
    next_state           = state;
    next_timer           = timer;
    next_ch              = ch;
    next_res_high_active = res_high_active;
    next_fast_active     = fast_active;
    next_scale_active    = scale_active;
    point_done           = 1'b0;
    case (state)
      adv_pkg::SEQ_IDLE: begin
        next_res_high_active = cfg_res_high;
        next_fast_active     = cfg_fast_cycle;
        next_scale_active    = cfg_scale_en && !cfg_res_high && !cfg_fast_cycle;
        next_timer           = '0;
        next_ch              = '0;
        next_state           = adv_pkg::SEQ_RUN;
      end
      adv_pkg::SEQ_RUN: begin
        if (timer == (fast_active ? FAST_LAST : STD_LAST)) begin
          point_done = 1'b1;
          next_timer = '0;
          next_ch    = ch + 1'b1;
        end else begin
          next_timer = timer + 1'b1;
        end
      end
      default: begin
        next_state = adv_pkg::SEQ_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state           <= adv_pkg::SEQ_IDLE;
      timer           <= '0;
      ch              <= '0;
      res_high_active <= 1'b0;
      fast_active     <= 1'b0;
      scale_active    <= 1'b0;
    end else begin
      state           <= next_state;
      timer           <= next_timer;
      ch              <= next_ch;
      res_high_active <= next_res_high_active;
      fast_active     <= next_fast_active;
      scale_active    <= next_scale_active;
    end
  end

  // ==========================================================
  // conversion enable flags
  logic                              host_run_d;
  logic                              next_host_run_d;
  logic [adv_pkg::CH_NUM-1:0]        next_conv_enable_flag;

  // leaving run mode wins over a set in the same cycle
  always_comb begin
    next_host_run_d       = host_run;
    next_conv_enable_flag = (conv_enable_flag & ~conv_enable_clr) | conv_enable_set;
    if (host_run_d && !host_run) begin
      next_conv_enable_flag = '0;
    end
  end

  // flag registers, cleared by any reset
  always_ff @(posedge clk) begin
    if (rst) begin
      host_run_d       <= 1'b0;
      conv_enable_flag <= '0;
    end else begin
      host_run_d       <= next_host_run_d;
      conv_enable_flag <= next_conv_enable_flag;
    end
  end

  // ==========================================================
  // current point fed to the conversion core
  always_comb begin
    pt.range_sel   = range_sel[ch];
    pt.hold_mode   = hold_mode[ch];
    pt.set_value   = set_value[ch];
    pt.scale_lower = scale_lower[ch];
    pt.scale_upper = scale_upper[ch];
    pt.last_code   = dac_code[ch];
    pt.res_hi      = res_high_active;
    pt.scale_on    = scale_active;
    pt.hold_req    = !conv_enable_flag[ch] || !host_run;
  end

  // ==========================================================
  // output codes and error flags
  logic [adv_pkg::CH_NUM-1:0][adv_pkg::DW-1:0] next_dac_code;
  logic [adv_pkg::CH_NUM-1:0]                  next_setting_error;
  logic                                        next_dac_load;
  logic [adv_pkg::CH_W-1:0]                    next_dac_channel;

  // one channel updated per finished point
  always_comb begin
    next_dac_code      = dac_code;
    next_setting_error = setting_error;
    next_dac_load      = point_done;
    next_dac_channel   = point_done ? ch : dac_channel;
    if (point_done) begin
      next_dac_code[ch]      = pt.code;
      next_setting_error[ch] = pt.range_err;
    end
  end

  // output registers start at the minimum code of the default range
  always_ff @(posedge clk) begin
    if (rst) begin
      dac_code      <= '0;
      setting_error <= '0;
      dac_load      <= 1'b0;
      dac_channel   <= '0;
    end else begin
      dac_code      <= next_dac_code;
      setting_error <= next_setting_error;
      dac_load      <= next_dac_load;
      dac_channel   <= next_dac_channel;
    end
  end

endmodule : adv_output_ctrl

/* testbench/adv_host_model.sv */
`timescale 1ns/1ps
module adv_host_model (
  input  logic       clk,
  input  logic       run_req,
  input  logic [7:0] en_req,
  output logic       host_run,
  output logic [7:0] conv_enable_set,
  output logic [7:0] conv_enable_clr
);
  // ==========================================================
  // host side: writes at the falling edge, a stopped host writes nothing
  logic       run_q = 1'b0;
  logic [7:0] en_q  = 8'h00;

  initial begin
    host_run = 1'b0;
    conv_enable_set = 8'h00;
    conv_enable_clr = 8'h00;
  end

  // bench commands taken at the rising edge, where they are settled
  always @(posedge clk) begin
    run_q <= run_req;
    en_q <= en_req;
  end

  // run state and enable requests follow the bench commands
  always @(negedge clk) begin
    host_run <= run_q;
    conv_enable_set <= run_q ? en_q : 8'h00;
    conv_enable_clr <= run_q ? ~en_q : 8'h00;
  end
endmodule : adv_host_model

/* testbench/adv_output_ctrl_properties.sv */
`timescale 1ns/1ps
module adv_props #(
  parameter int STD_CNT  = 8,
  parameter int FAST_CNT = 4
) (
  input logic                                        clk,
  input logic                                        rst,
  input logic                                        host_run,
  input logic [adv_pkg::CH_NUM-1:0]                  conv_enable_set,
  input logic [adv_pkg::CH_NUM-1:0][1:0]             range_sel,
  input logic [adv_pkg::CH_NUM-1:0][1:0]             hold_mode,
  input logic [adv_pkg::CH_NUM-1:0][adv_pkg::DW-1:0] dac_code,
  input logic                                        dac_load,
  input logic [adv_pkg::CH_W-1:0]                    dac_channel,
  input logic [adv_pkg::CH_NUM-1:0]                  conv_enable_flag,
  input logic [adv_pkg::CH_NUM-1:0]                  setting_error,
  input logic                                        res_high_active,
  input logic                                        fast_active,
  input logic                                        scale_active
);
  // ==========================================================
  // helper state: inputs as seen at the conversion edge
  logic                                        run_q;
  logic [adv_pkg::CH_NUM-1:0]                  flg_q;
  logic [adv_pkg::CH_NUM-1:0][1:0]             hm_q;
  logic [adv_pkg::CH_NUM-1:0][1:0]             rs_q;
  logic [adv_pkg::CH_NUM-1:0][adv_pkg::DW-1:0] code_q;
  int                                          gap;
  logic                                        seen;
  logic [1:0]                                  up;

  // delayed copies, load gap counter and settle counter
  always_ff @(posedge clk) begin
    run_q <= host_run;
    flg_q <= conv_enable_flag;
    hm_q <= hold_mode;
    rs_q <= range_sel;
    code_q <= dac_code;
    if (rst) begin
      gap <= 0;
      seen <= 1'b0;
      up <= 2'h0;
    end else begin
      gap <= dac_load ? 1 : gap + 1;
      seen <= seen | dac_load;
      up <= (up == 2'h3) ? up : up + 2'h1;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_run_exit;
    host_run ##1 !host_run;
  endsequence

  chk_load_pulse: assert property (dac_load |=> !dac_load)
    else $error("load pulse longer than one cycle");
  chk_load_period: assert property (dac_load && seen |->
    gap == (fast_active ? FAST_CNT : STD_CNT))
    else $error("conversion spacing wrong");
  chk_chan_order: assert property (dac_load && seen |->
    dac_channel == $past(dac_channel) + 3'h1)
    else $error("channel order wrong");
  chk_run_exit: assert property (s_run_exit |=> conv_enable_flag == '0)
    else $error("enable flags kept after run exit");
  chk_flag_set: assert property (|conv_enable_set && !(run_q && !host_run) |=>
    (conv_enable_flag & $past(conv_enable_set)) == $past(conv_enable_set))
    else $error("enable flag not set");
  chk_keep_hold: assert property (dac_load && hm_q[dac_channel] == adv_pkg::HOLD_KEEP &&
    (!run_q || !flg_q[dac_channel]) |-> dac_code[dac_channel] == code_q[dac_channel])
    else $error("keep hold changed the code");
  chk_err_max: assert property (dac_load && setting_error[dac_channel] &&
    !res_high_active && hm_q[dac_channel] == adv_pkg::HOLD_MAX &&
    rs_q[dac_channel] != adv_pkg::RANGE_BIPOL
    |-> dac_code[dac_channel] == adv_pkg::RES_STD)
    else $error("error did not give maximum");
  chk_stop_clear: assert property (dac_load && !run_q &&
    hm_q[dac_channel] == adv_pkg::HOLD_CLEAR &&
    rs_q[dac_channel] != adv_pkg::RANGE_BIPOL |-> dac_code[dac_channel] == '0)
    else $error("stopped host did not clear");
  chk_cfg_fixed: assert property (up == 2'h3 |->
    $stable({res_high_active, fast_active, scale_active}))
    else $error("latched configuration moved");
  chk_scale_gate: assert property (scale_active |-> !res_high_active && !fast_active)
    else $error("scaling with wrong cycle or resolution");
endmodule : adv_props

bind adv_output_ctrl adv_props #(.STD_CNT(STD_CNT), .FAST_CNT(FAST_CNT)) adv_props_inst (
  .clk(clk), .rst(rst), .host_run(host_run), .conv_enable_set(conv_enable_set),
  .range_sel(range_sel), .hold_mode(hold_mode), .dac_code(dac_code), .dac_load(dac_load),
  .dac_channel(dac_channel), .conv_enable_flag(conv_enable_flag), .setting_error(setting_error),
  .res_high_active(res_high_active), .fast_active(fast_active), .scale_active(scale_active)
);

/* testbench/test_adv_output_ctrl.sv */
`timescale 1ns/1ps
module test_adv_output_ctrl;
  localparam int N = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run_req = 1'b0;
  logic [7:0] en_req = 8'h00;
  logic cfg_res_high = 1'b0;
  logic cfg_fast_cycle = 1'b0;
  logic cfg_scale_en = 1'b0;
  logic host_run, dac_load, res_high_active, fast_active, scale_active;
  logic [7:0] conv_enable_set, conv_enable_clr, conv_enable_flag, setting_error;
  logic [2:0] dac_channel;
  logic [7:0][1:0] range_sel = '0;
  logic [7:0][1:0] hold_mode = '0;
  logic [7:0][15:0] set_value = '0;
  logic [7:0][15:0] scale_lower = '0;
  logic [7:0][15:0] scale_upper = '0;
  logic [7:0][15:0] dac_code;
  logic [15:0] exp_code [8];
  logic exp_err [8];
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  // ==========================================================
  // clock, cycle count, design and host
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  adv_output_ctrl #(.STD_CNT(N), .FAST_CNT(N / 2)) adv_output_ctrl_inst (
    .clk(clk), .rst(rst), .host_run(host_run), .cfg_res_high(cfg_res_high),
    .cfg_fast_cycle(cfg_fast_cycle), .cfg_scale_en(cfg_scale_en),
    .conv_enable_set(conv_enable_set), .conv_enable_clr(conv_enable_clr),
    .range_sel(range_sel), .hold_mode(hold_mode), .set_value(set_value),
    .scale_lower(scale_lower), .scale_upper(scale_upper), .dac_code(dac_code),
    .dac_load(dac_load), .dac_channel(dac_channel), .conv_enable_flag(conv_enable_flag),
    .setting_error(setting_error), .res_high_active(res_high_active),
    .fast_active(fast_active), .scale_active(scale_active));

  adv_host_model adv_host_model_inst (
    .clk(clk), .run_req(run_req), .en_req(en_req), .host_run(host_run),
    .conv_enable_set(conv_enable_set), .conv_enable_clr(conv_enable_clr));

  // ==========================================================
  // shared tasks
  task automatic conclude();
    $display("checks %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_load(input int ch);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      if (dac_load === 1'b1 && dac_channel === ch[2:0]) break;
    end
    if (i == 200) begin
      errors++;
      conclude();
    end
  endtask : wait_load

  task automatic set_ch(input int c, input logic [1:0] r, input logic [1:0] h,
                        input logic [15:0] v, input logic [15:0] e, input logic er);
    range_sel[c] = r;
    hold_mode[c] = h;
    set_value[c] = v;
    exp_code[c] = e;
    exp_err[c] = er;
  endtask : set_ch

  task automatic check_all(input int n);
    for (int c = 0; c < n; c++) begin
      wait_load(c);
      check("code", dac_code[c], exp_code[c]);
      check("error", {15'h0, setting_error[c]}, {15'h0, exp_err[c]});
    end
  endtask : check_all

  task automatic do_reset(input logic r, input logic f, input logic s);
    @(negedge clk);
    rst = 1'b1;
    en_req = 8'h00;
    cfg_res_high = r;
    cfg_fast_cycle = f;
    cfg_scale_en = s;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    check("res", {15'h0, res_high_active}, {15'h0, r});
    check("fast", {15'h0, fast_active}, {15'h0, f});
    check("scale", {15'h0, scale_active}, {15'h0, s & ~r & ~f});
    check("flags", {8'h0, conv_enable_flag}, 16'h0000);
  endtask : do_reset

  task automatic sc_period(input int n);
    int t0;
    wait_load(0);
    t0 = cyc;
    wait_load(1);
    check("period", 16'(cyc - t0), 16'(n));
  endtask : sc_period

  // ==========================================================
  // scenarios
  task automatic sc_ranges();
    @(negedge clk);
    run_req = 1'b1;
    en_req = 8'hbf;
    set_ch(0, adv_pkg::RANGE_0_10V, adv_pkg::HOLD_CLEAR, 16'h04d2, 16'h04d2, 1'b0);
    set_ch(1, adv_pkg::RANGE_BIPOL, adv_pkg::HOLD_CLEAR, 16'hf830, 16'hf830, 1'b0);
    set_ch(2, adv_pkg::RANGE_0_10V, adv_pkg::HOLD_CLEAR, 16'h1069, 16'h0000, 1'b1);
    set_ch(3, adv_pkg::RANGE_0_5V, adv_pkg::HOLD_MAX, 16'hff37, 16'h0fa0, 1'b1);
    set_ch(4, adv_pkg::RANGE_BIPOL, adv_pkg::HOLD_MAX, 16'h0899, 16'h07d0, 1'b1);
    set_ch(5, adv_pkg::RANGE_1_5V, adv_pkg::HOLD_CLEAR, 16'h0fa0, 16'h0fa0, 1'b0);
    set_ch(6, adv_pkg::RANGE_BIPOL, adv_pkg::HOLD_MAX, 16'h0000, 16'h07d0, 1'b0);
    set_ch(7, adv_pkg::RANGE_0_5V, adv_pkg::HOLD_KEEP, 16'h1069, 16'h0000, 1'b1);
    repeat (2) @(negedge clk);
    check("flags", {8'h0, conv_enable_flag}, 16'h00bf);
    check_all(8);
  endtask : sc_ranges

  task automatic sc_stop();
    @(negedge clk);
    run_req = 1'b0;
    set_ch(0, adv_pkg::RANGE_0_10V, adv_pkg::HOLD_KEEP, 16'h0064, 16'h04d2, 1'b0);
    set_ch(1, adv_pkg::RANGE_BIPOL, adv_pkg::HOLD_MAX, 16'h0064, 16'h07d0, 1'b0);
    set_ch(2, adv_pkg::RANGE_0_10V, adv_pkg::HOLD_CLEAR, 16'h0064, 16'h0000, 1'b0);
    repeat (2) @(negedge clk);
    check("flags", {8'h0, conv_enable_flag}, 16'h0000);
    check_all(3);
  endtask : sc_stop

  task automatic sc_fast();
    do_reset(1'b1, 1'b1, 1'b1);
    run_req = 1'b1;
    en_req = 8'h03;
    set_ch(0, adv_pkg::RANGE_0_10V, adv_pkg::HOLD_CLEAR, 16'h1f40, 16'h1f40, 1'b0);
    set_ch(1, adv_pkg::RANGE_0_10V, adv_pkg::HOLD_MAX, 16'h20d1, 16'h1f40, 1'b1);
    repeat (2) @(negedge clk);
    check_all(2);
    sc_period(N / 2);
  endtask : sc_fast

  task automatic sc_scale();
    do_reset(1'b0, 1'b0, 1'b1);
    run_req = 1'b1;
    en_req = 8'h07;
    scale_lower[0] = 16'hfc18;
    scale_upper[0] = 16'h03e8;
    scale_upper[1] = 16'h7d01;
    scale_lower[2] = 16'h03e8;
    scale_upper[2] = 16'h03e8;
    set_ch(0, adv_pkg::RANGE_0_10V, adv_pkg::HOLD_CLEAR, 16'h0000, 16'h07d0, 1'b0);
    set_ch(1, adv_pkg::RANGE_0_10V, adv_pkg::HOLD_MAX, 16'h0000, 16'h0fa0, 1'b1);
    set_ch(2, adv_pkg::RANGE_0_10V, adv_pkg::HOLD_MAX, 16'h03e8, 16'h0fa0, 1'b1);
    repeat (2) @(negedge clk);
    check_all(3);
  endtask : sc_scale

  // main sequence
  initial begin
    do_reset(1'b0, 1'b0, 1'b0);
    sc_ranges();
    sc_period(N);
    sc_stop();
    sc_fast();
    sc_scale();
    conclude();
  end
endmodule : test_adv_output_ctrl
